// >>> core/dmat_params.svh
// dmat_params.svh: register map, bit positions and reset values of the dma termination block
// assumes: included by its bare name from every design file that needs it
`ifndef DMAT_PARAMS_SVH
`define DMAT_PARAMS_SVH

// register addresses on the plain register port
`define DMAT_REG_MODE   8'h00
`define DMAT_REG_STATUS 8'h01
`define DMAT_REG_MASK   8'h02
`define DMAT_REG_SRC    8'h03
`define DMAT_REG_DST    8'h04
`define DMAT_REG_COUNT  8'h05
`define DMAT_REG_FCODE  8'h06
`define DMAT_REG_BASE   8'h07
`define DMAT_REG_CMD    8'h08
`define DMAT_REG_STATE  8'h09
// descriptor memory window: addresses 8'h40..8'h7F, one word each
`define DMAT_MEM_SEL    2'h1
`define DMAT_MEM_WORDS  64
`define DMAT_CMD_INIT   32'h00000001
// reset values
`define DMAT_MODE_RST   7'h00
`define DMAT_STAT_RST   3'h0
// channel status bits
`define DMAT_ST_DONE    0
`define DMAT_ST_AUX     1
`define DMAT_ST_OOB     2
// descriptor status word bits
`define DMAT_BD_VALID   15
`define DMAT_BD_WRAP    13
`define DMAT_BD_INTR    12
`define DMAT_BD_LAST    11
`define DMAT_BD_CONT    9
`define DMAT_BD_ABORT   1
`define DMAT_BD_EXTEND  0
// descriptor word offsets
`define DMAT_OFS_STAT   2'h0
`define DMAT_OFS_LEN    2'h1
`define DMAT_OFS_SRC    2'h2
`define DMAT_OFS_DST    2'h3
// function code fields
`define DMAT_FC_SRC     7:4
`define DMAT_FC_DST     3:0
`endif

// >>> core/dmat_pkg.sv
// dmat_pkg.sv: types shared by the dma termination block
// assumes: nothing beyond the tool's SystemVerilog support
package dmat_pkg;
  // descriptor handling mode of the channel
  typedef enum logic [1:0] {
    BM_SINGLE = 2'h0,
    BM_AUTO   = 2'h1,
    BM_CHAIN  = 2'h2
  } dmat_bmode_e;

  // channel sequencer: idle, descriptor fetch and close, plus one state per bus phase
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_FETCH = 4'h1,
    ST_SRC1  = 4'h2,
    ST_SRC3  = 4'h3,
    ST_SRC5  = 4'h4,
    ST_DST1  = 4'h5,
    ST_DST3  = 4'h6,
    ST_DST5  = 4'h7,
    ST_CLOSE = 4'h8
  } dmat_state_e;

  // channel mode register, high bits first
  typedef struct packed {
    dmat_bmode_e bmode;
    logic        dual;
    logic        hs_dest;
    logic        sync_bypass;
    logic        chan_reset;
    logic        run;
  } dmat_mode_s;

  // one bus request toward memory or peripheral
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
    logic [3:0]  fc;
    logic        rd;
    logic        wr;
  } dmat_bus_s;
endpackage

// >>> core/dmat_end_sampler.sv
// dmat_end_sampler.sv: conditions the external end line before the sample point
// assumes: line is active low and idles high when nobody drives it
`timescale 1ns/1ns
`default_nettype none

module dmat_end_sampler (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic end_line_in,
  input  wire logic bypass_in,
  output logic      end_now_out
);
  logic sync_a;
  logic sync_b;

  // two-stage synchroniser, idle level is high
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= end_line_in;
      sync_b <= sync_a;
    end
  end

  // bypass picks the raw line, else the synchronised copy
  assign end_now_out = bypass_in ? ~end_line_in : ~sync_b;
endmodule
`default_nettype wire

// >>> core/dmat_desc_store.sv
// dmat_desc_store.sv: internal dual-port memory that holds the descriptors
// assumes: the sequencer port wins when both ports write the same word
`timescale 1ns/1ns
`default_nettype none
`include "dmat_params.svh"

module dmat_desc_store (
  input  wire logic        clk_in,
  input  wire logic [5:0]  sw_addr_in,
  input  wire logic [31:0] sw_wdata_in,
  input  wire logic        sw_wr_in,
  output logic      [31:0] sw_rdata_out,
  input  wire logic [5:0]  cp_addr_in,
  input  wire logic [31:0] cp_wdata_in,
  input  wire logic        cp_wr_in,
  output logic      [31:0] cp_rdata_out
);
  logic [31:0] mem [0:`DMAT_MEM_WORDS-1];

  // both write ports, registered software read
  always_ff @(posedge clk_in) begin
    if (cp_wr_in) begin
      mem[cp_addr_in] <= cp_wdata_in;
    end
    if (sw_wr_in && !(cp_wr_in && cp_addr_in == sw_addr_in)) begin
      mem[sw_addr_in] <= sw_wdata_in;
    end
    sw_rdata_out <= mem[sw_addr_in];
  end

  // sequencer reads the word in the same cycle
  assign cp_rdata_out = mem[cp_addr_in];
endmodule
`default_nettype wire

// >>> core/dmat_channel.sv
// dmat_channel.sv: one general_dma_channel with end-of-transfer handling and descriptor control
// assumes: single 10 MHz clock, synchronous inputs, peripheral on request/ack/end handshake
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dmat_params.svh"

module dmat_channel (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [31:0]       reg_rdata_out,
  output dmat_pkg::dmat_bus_s    bus_out,
  input  wire logic [7:0]        bus_data_in,
  input  wire logic [1:0]        cycle_ack_lines_n_in,
  output logic                   request_ack_line_n_out,
  input  wire logic              transfer_end_line_in,
  output logic                   transfer_end_line_out,
  output logic                   transfer_end_line_oe_out,
  output logic                   done_irq_out
);
  dmat_pkg::dmat_mode_s  mode;
  dmat_pkg::dmat_state_e state;
  logic [2:0]  status;
  logic [2:0]  mask;
  logic [31:0] src_ptr;
  logic [31:0] dst_ptr;
  logic [31:0] count;
  logic [7:0]  fcode;
  logic [15:0] base;
  logic [1:0]  fw;
  logic [3:0]  idx;
  logic        loaded;
  logic        end_pend;
  logic        close_ext;
  logic [15:0] cur_stat;
  logic [7:0]  data_hold;
  logic [31:0] reg_rdata;
  logic        rd_mem;
  logic [31:0] sw_rdata;
  logic [31:0] cp_rdata;
  logic [31:0] cp_wdata;
  logic [5:0]  cp_addr;
  logic        cp_wr;
  logic        end_now;

  // true in any phase of a source or destination bus cycle
  function automatic logic is_src(input dmat_pkg::dmat_state_e s);
    is_src = (s == dmat_pkg::ST_SRC1) || (s == dmat_pkg::ST_SRC3) || (s == dmat_pkg::ST_SRC5);
  endfunction
  function automatic logic is_dst(input dmat_pkg::dmat_state_e s);
    is_dst = (s == dmat_pkg::ST_DST1) || (s == dmat_pkg::ST_DST3) || (s == dmat_pkg::ST_DST5);
  endfunction

  // decoded conditions of the current cycle
  logic sw_mem;
  logic single;
  logic chain;
  logic hs_src;
  logic hs_cycle;
  logic acked;
  logic late;
  logic sample_pt;
  logic end_hit;
  logic at_byte_end;
  logic ext;
  logic zero;
  logic idle_ok;
  dmat_pkg::dmat_state_e first_cyc;
  assign sw_mem      = reg_addr_in[7:6] == `DMAT_MEM_SEL;
  assign single      = mode.bmode == dmat_pkg::BM_SINGLE;
  assign chain       = mode.bmode == dmat_pkg::BM_CHAIN;
  assign hs_src      = ~mode.hs_dest;
  assign hs_cycle    = mode.dual ? ((is_src(state) & hs_src) | (is_dst(state) & ~hs_src))
                                 : (is_src(state) | is_dst(state));
  assign acked       = ~&cycle_ack_lines_n_in;
  assign late        = hs_src & mode.dual;
  assign sample_pt   = hs_cycle & ~transfer_end_line_oe_out &
                       (late ? (state == dmat_pkg::ST_SRC5)
                             : ((state == dmat_pkg::ST_SRC3 || state == dmat_pkg::ST_DST3) & acked));
  assign end_hit     = sample_pt & end_now;
  assign at_byte_end = ((state == dmat_pkg::ST_DST5) & (mode.dual | hs_src)) |
                       ((state == dmat_pkg::ST_SRC5) & ~mode.dual & ~hs_src);
  assign ext         = end_pend | end_hit;
  assign zero        = count == 32'h00000001;
  assign idle_ok     = state == dmat_pkg::ST_IDLE;
  assign first_cyc   = (mode.dual | ~hs_src) ? dmat_pkg::ST_SRC1 : dmat_pkg::ST_DST1;

  // hardware events and the software init command toward the mode and status registers
  logic p_oob;
  logic p_done;
  logic p_aux;
  logic p_rst_set;
  logic p_init;
  assign p_oob     = (state == dmat_pkg::ST_FETCH) & (fw == `DMAT_OFS_STAT) & ~cp_rdata[`DMAT_BD_VALID];
  assign p_done    = (at_byte_end & single & (ext | zero)) |
                     ((state == dmat_pkg::ST_CLOSE) & (close_ext | (chain & cur_stat[`DMAT_BD_LAST])));
  assign p_aux     = (state == dmat_pkg::ST_CLOSE) & ~close_ext & cur_stat[`DMAT_BD_INTR];
  assign p_rst_set = (state == dmat_pkg::ST_CLOSE) & close_ext & chain;
  assign p_init    = reg_wr_in & (reg_addr_in == `DMAT_REG_CMD) & (reg_wdata_in == `DMAT_CMD_INIT);

  dmat_end_sampler u_sampler (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .end_line_in (transfer_end_line_in),
    .bypass_in   (mode.sync_bypass),
    .end_now_out (end_now)
  );

  // descriptor word address from base, index and word offset
  assign cp_addr = 6'(base[5:0] + {idx, 2'h0} + {4'h0, fw});
  assign cp_wr   = state == dmat_pkg::ST_CLOSE;
  always_comb begin
    cp_wdata = {16'h0000, cur_stat};
    if (close_ext) begin
      cp_wdata[`DMAT_BD_VALID] = 1'b0;
      if (chain) begin
        cp_wdata[`DMAT_BD_ABORT] = 1'b1;
      end else begin
        cp_wdata[`DMAT_BD_EXTEND] = 1'b1;
      end
    end else if (!cur_stat[`DMAT_BD_CONT]) begin
      cp_wdata[`DMAT_BD_VALID] = 1'b0;
    end
  end

  dmat_desc_store u_store (
    .clk_in       (clk_in),
    .sw_addr_in   (reg_addr_in[5:0]),
    .sw_wdata_in  (reg_wdata_in),
    .sw_wr_in     (reg_wr_in & sw_mem),
    .sw_rdata_out (sw_rdata),
    .cp_addr_in   (cp_addr),
    .cp_wdata_in  (cp_wdata),
    .cp_wr_in     (cp_wr),
    .cp_rdata_out (cp_rdata)
  );

  // mode register: hardware clear of run and set of reset win over software
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode <= dmat_pkg::dmat_mode_s'(`DMAT_MODE_RST);
    end else begin
      if (reg_wr_in && reg_addr_in == `DMAT_REG_MODE) begin
        mode <= dmat_pkg::dmat_mode_s'(reg_wdata_in[6:0]);
      end
      if (p_init && mode.chan_reset) begin
        mode.chan_reset <= 1'b0;
      end
      if (p_done || p_oob) begin
        mode.run <= 1'b0;
      end
      if (p_rst_set) begin
        mode.chan_reset <= 1'b1;
      end
    end
  end

  // status register: write one to clear, a new event wins
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      status <= `DMAT_STAT_RST;
    end else begin
      if (reg_wr_in && reg_addr_in == `DMAT_REG_STATUS) begin
        status <= status & ~reg_wdata_in[2:0];
      end
      if (p_done) begin
        status[`DMAT_ST_DONE] <= 1'b1;
      end
      if (p_aux) begin
        status[`DMAT_ST_AUX] <= 1'b1;
      end
      if (p_oob) begin
        status[`DMAT_ST_OOB] <= 1'b1;
      end
    end
  end

  // plain software registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mask  <= 3'h0;
      fcode <= 8'h00;
      base  <= 16'h0000;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `DMAT_REG_MASK) mask <= reg_wdata_in[2:0];
      if (reg_addr_in == `DMAT_REG_FCODE) fcode <= reg_wdata_in[7:0];
      if (reg_addr_in == `DMAT_REG_BASE) base <= reg_wdata_in[15:0];
    end
  end

  // pointers and count: software while idle, descriptor load and per-byte update otherwise
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      src_ptr <= 32'h00000000;
      dst_ptr <= 32'h00000000;
      count   <= 32'h00000000;
    end else if (state == dmat_pkg::ST_FETCH) begin
      if (fw == `DMAT_OFS_LEN) count <= cp_rdata;
      if (fw == `DMAT_OFS_SRC) src_ptr <= cp_rdata;
      if (fw == `DMAT_OFS_DST) dst_ptr <= cp_rdata;
    end else if (at_byte_end) begin
      src_ptr <= src_ptr + 32'h00000001;
      dst_ptr <= dst_ptr + 32'h00000001;
      count   <= count - 32'h00000001;
    end else if (reg_wr_in && idle_ok) begin
      if (reg_addr_in == `DMAT_REG_SRC) src_ptr <= reg_wdata_in;
      if (reg_addr_in == `DMAT_REG_DST) dst_ptr <= reg_wdata_in;
      if (reg_addr_in == `DMAT_REG_COUNT) count <= reg_wdata_in;
    end
  end

  // data from the source cycle, end seen on the source side waits for the destination
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      data_hold <= 8'h00;
      end_pend  <= 1'b0;
    end else begin
      if (state == dmat_pkg::ST_SRC3 && acked) data_hold <= bus_data_in;
      if (at_byte_end || idle_ok) begin
        end_pend <= 1'b0;
      end else if (end_hit) begin
        end_pend <= 1'b1;
      end
    end
  end

  // channel sequencer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state     <= dmat_pkg::ST_IDLE;
      fw        <= 2'h0;
      idx       <= 4'h0;
      loaded    <= 1'b0;
      close_ext <= 1'b0;
      cur_stat  <= 16'h0000;
    end else if (mode.chan_reset) begin
      state <= dmat_pkg::ST_IDLE;
      if (p_init) begin
        idx    <= 4'h0;
        loaded <= 1'b0;
      end
    end else begin
      unique case (state)
        dmat_pkg::ST_IDLE: begin
          fw        <= `DMAT_OFS_STAT;
          close_ext <= 1'b0;
          if (mode.run) begin
            state <= (!single && !loaded) ? dmat_pkg::ST_FETCH : first_cyc;
          end
        end
        dmat_pkg::ST_FETCH: begin
          fw <= 2'(fw + 2'h1);
          if (fw == `DMAT_OFS_STAT) cur_stat <= cp_rdata[15:0];
          if (p_oob) begin
            state <= dmat_pkg::ST_IDLE;
          end else if (fw == `DMAT_OFS_DST) begin
            loaded <= 1'b1;
            state  <= first_cyc;
          end
        end
        dmat_pkg::ST_SRC1: state <= dmat_pkg::ST_SRC3;
        dmat_pkg::ST_SRC3: if (acked) state <= dmat_pkg::ST_SRC5;
        dmat_pkg::ST_DST1: state <= dmat_pkg::ST_DST3;
        dmat_pkg::ST_DST3: if (acked) state <= dmat_pkg::ST_DST5;
        dmat_pkg::ST_SRC5,
        dmat_pkg::ST_DST5: begin
          fw <= `DMAT_OFS_STAT;
          if (!at_byte_end) begin
            state <= dmat_pkg::ST_DST1;
          end else if (ext) begin
            close_ext <= 1'b1;
            state     <= single ? dmat_pkg::ST_IDLE : dmat_pkg::ST_CLOSE;
          end else if (zero && single) begin
            state <= dmat_pkg::ST_IDLE;
          end else if (zero) begin
            state <= dmat_pkg::ST_CLOSE;
          end else if (!mode.run) begin
            state <= dmat_pkg::ST_IDLE;
          end else begin
            state <= first_cyc;
          end
        end
        dmat_pkg::ST_CLOSE: begin
          idx <= cur_stat[`DMAT_BD_WRAP] ? 4'h0 : 4'(idx + 4'h1);
          if (close_ext || (chain && cur_stat[`DMAT_BD_LAST])) begin
            loaded <= 1'b0;
            state  <= dmat_pkg::ST_IDLE;
          end else if (!mode.run) begin
            loaded <= 1'b0;
            state  <= dmat_pkg::ST_IDLE;
          end else begin
            state <= dmat_pkg::ST_FETCH;
          end
        end
        default: state <= dmat_pkg::ST_IDLE;
      endcase
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata <= 32'h00000000;
      rd_mem    <= 1'b0;
    end else begin
      rd_mem    <= reg_rd_in & sw_mem;
      reg_rdata <= 32'h00000000;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          `DMAT_REG_MODE:   reg_rdata <= {25'h0000000, mode};
          `DMAT_REG_STATUS: reg_rdata <= {29'h00000000, status};
          `DMAT_REG_MASK:   reg_rdata <= {29'h00000000, mask};
          `DMAT_REG_SRC:    reg_rdata <= src_ptr;
          `DMAT_REG_DST:    reg_rdata <= dst_ptr;
          `DMAT_REG_COUNT:  reg_rdata <= count;
          `DMAT_REG_FCODE:  reg_rdata <= {24'h000000, fcode};
          `DMAT_REG_BASE:   reg_rdata <= {16'h0000, base};
          `DMAT_REG_STATE:  reg_rdata <= {23'h000000, loaded, idx, state};
          default:          reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
  assign reg_rdata_out = rd_mem ? sw_rdata : reg_rdata;

  // bus request, handshake and end line drive
  always_comb begin
    bus_out      = '0;
    bus_out.data = data_hold;
    if (is_src(state)) begin
      bus_out.addr = src_ptr;
      bus_out.fc   = fcode[`DMAT_FC_SRC];
      bus_out.rd   = 1'b1;
    end else if (is_dst(state)) begin
      bus_out.addr = dst_ptr;
      bus_out.fc   = fcode[`DMAT_FC_DST];
      bus_out.wr   = 1'b1;
    end
  end
  assign request_ack_line_n_out   = ~hs_cycle;
  assign transfer_end_line_out    = 1'b0;
  assign transfer_end_line_oe_out = hs_cycle & zero & (single | (chain & cur_stat[`DMAT_BD_LAST]));
  assign done_irq_out             = |(status & mask);

  // checks on the termination behaviour
  a_sample_s3: assert property (@(posedge clk_in) disable iff (reset_in)
    (end_hit && !late) |-> ((state == dmat_pkg::ST_SRC3 || state == dmat_pkg::ST_DST3) && acked))
    else $error("end line taken outside the last third state");
  a_sample_s5: assert property (@(posedge clk_in) disable iff (reset_in)
    (end_hit && late) |-> (state == dmat_pkg::ST_SRC5))
    else $error("late sample not in fifth state");
  a_sync_delay: assert property (@(posedge clk_in) disable iff (reset_in)
    (!mode.sync_bypass && !transfer_end_line_in ##1 !mode.sync_bypass && !transfer_end_line_in) |=> end_now)
    else $error("synchronised end line not seen two clocks later");
  a_src_finish: assert property (@(posedge clk_in) disable iff (reset_in)
    (end_hit && is_src(state) && mode.dual && !mode.chan_reset) |=> (state == dmat_pkg::ST_DST1) ##1
    (state == dmat_pkg::ST_DST3))
    else $error("destination access skipped after source end");
  a_dst_stop: assert property (@(posedge clk_in) disable iff (reset_in)
    (end_hit && state == dmat_pkg::ST_DST3 && single && !mode.chan_reset) |-> ##2
    (state == dmat_pkg::ST_IDLE && !mode.run))
    else $error("cycles continue after destination end");
  a_ext_done: assert property (@(posedge clk_in) disable iff (reset_in)
    (at_byte_end && single && ext && !mode.chan_reset) |=> (status[`DMAT_ST_DONE] && !mode.run))
    else $error("external end did not set done and clear run");
  a_count_dec: assert property (@(posedge clk_in) disable iff (reset_in)
    (at_byte_end && !mode.chan_reset) |=> (count == $past(count) - 32'h00000001))
    else $error("count not decremented per byte");
  a_oob_stop: assert property (@(posedge clk_in) disable iff (reset_in)
    (p_oob && !mode.chan_reset) |=> (status[`DMAT_ST_OOB] && state == dmat_pkg::ST_IDLE && !mode.run))
    else $error("invalid descriptor did not stop the channel");
  a_chain_abort: assert property (@(posedge clk_in) disable iff (reset_in)
    (state == dmat_pkg::ST_CLOSE && close_ext && chain && !mode.chan_reset) |=>
    (mode.chan_reset && !mode.run && status[`DMAT_ST_DONE]))
    else $error("chain abort did not reset the channel");
endmodule
`default_nettype wire

// >>> tb/dmat_periph_model.sv
// dmat_periph_model.sv: peripheral and memory on the far side of the channel
// assumes: channel bus request struct, active low acks and end line
`timescale 1ns/1ns
`default_nettype none
module dmat_periph_model (
  input  wire logic                clk_in,
  input  wire dmat_pkg::dmat_bus_s bus_in,
  input  wire logic                req_ack_n_in,
  input  wire logic                end_req_in,
  input  wire logic [3:0]          waits_in,
  output logic      [7:0]          data_out,
  output logic      [1:0]          ack_n_out,
  output logic                     end_drive_out
);
  logic [1:0] prev;
  logic [3:0] cnt;
  logic [3:0] eff;
  // phase counter restarts on each new cycle kind
  always_ff @(posedge clk_in) begin
    prev <= {bus_in.rd, bus_in.wr};
    cnt  <= eff + 4'h1;
  end
  assign eff = ({bus_in.rd, bus_in.wr} != prev) ? 4'h0 : cnt;
  // ack after the wait states, end line no later than it
  assign ack_n_out     = ((bus_in.rd | bus_in.wr) && eff >= waits_in + 4'h1) ? 2'h2 : 2'h3;
  assign end_drive_out = end_req_in & ~req_ack_n_in;
  // read data from the address, inverted when not read
  assign data_out = bus_in.rd ? bus_in.addr[7:0] : ~bus_in.addr[7:0];
endmodule
`default_nettype wire

// >>> tb/dmat_channel_tb_top.sv
// dmat_channel_tb_top.sv: self-checking bench of the dma termination channel
// assumes: peripheral model on the bus side, register port driven here
`timescale 1ns/1ns
`default_nettype none
`include "dmat_params.svh"
module dmat_channel_tb_top;
  logic                clk_in = 1'b0;
  logic                reset_in = 1'b1;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic                end_req = 1'b0;
  logic                wr_prev = 1'b0;
  logic [7:0]          reg_addr = 8'h00;
  logic [31:0]         reg_wdata = 32'h0;
  logic [31:0]         rdata;
  logic [31:0]         v;
  logic [3:0]          waits = 4'h0;
  logic [3:0]          fc_seen = 4'h0;
  logic [7:0]          bdata;
  logic [1:0]          ack_n;
  logic                req_ack_n;
  logic                end_oe;
  logic                end_drv;
  logic                irq;
  logic                end_out;
  int                  oe_seen = 0;
  dmat_pkg::dmat_bus_s bus;
  int                  mismatches = 0;
  int                  compares = 0;
  int                  wr_seen = 0;
  int                  w0;
  wire                 end_wire = end_oe ? end_out : ~end_drv; // channel level when enabled, else low while the peripheral drives end, high otherwise

  // clock generator
  always #50 clk_in = ~clk_in;

  dmat_channel dut_u (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .bus_out(bus), .bus_data_in(bdata),
    .cycle_ack_lines_n_in(ack_n), .request_ack_line_n_out(req_ack_n), .transfer_end_line_in(end_wire),
    .transfer_end_line_out(end_out), .transfer_end_line_oe_out(end_oe), .done_irq_out(irq));
  dmat_periph_model peer_u (.clk_in(clk_in), .bus_in(bus), .req_ack_n_in(req_ack_n), .end_req_in(end_req),
    .waits_in(waits), .data_out(bdata), .ack_n_out(ack_n), .end_drive_out(end_drv));

  // count write cycles and note the source function code
  always @(posedge clk_in) begin
    wr_prev <= bus.wr;
    if (bus.wr && !wr_prev) wr_seen <= wr_seen + 1;
    if (bus.rd) fc_seen <= bus.fc;
    if (end_oe && !end_wire) oe_seen <= oe_seen + 1;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask

  // load a transfer in the given mode, start it and wait for run to clear
  task automatic run(input logic [31:0] s, input logic [31:0] n, input logic [31:0] mode);
    int k;
    wr(`DMAT_REG_STATUS, 32'h7);
    wr(`DMAT_REG_MASK, 32'h1);
    wr(`DMAT_REG_FCODE, 32'h89);
    wr(`DMAT_REG_SRC, s);
    wr(`DMAT_REG_DST, s + 32'h10);
    wr(`DMAT_REG_COUNT, n);
    w0 = wr_seen;
    wr(`DMAT_REG_MODE, mode);
    k = 0;
    v = 32'h1;
    while (v[0] === 1'b1 && k < 200) begin
      rd(`DMAT_REG_MODE, v);
      k++;
    end
    chk("run cleared", 32'h0, {31'h0, v[0]});
    chk("done", 32'h1, {31'h0, irq});
  endtask

  // check count, pointers and write cycles after a run
  task automatic after(input logic [31:0] s, input logic [31:0] left, input logic [31:0] moved, input int wrs);
    rchk("count", `DMAT_REG_COUNT, left);
    rchk("src", `DMAT_REG_SRC, s + moved);
    rchk("dst", `DMAT_REG_DST, s + 32'h10 + moved);
    chk("writes", wrs, wr_seen - w0);
  endtask

  task automatic t_regs;
    rchk("mode rst", `DMAT_REG_MODE, 32'h0);
    rchk("status rst", `DMAT_REG_STATUS, 32'h0);
    wr(8'h0A, 32'hFFFFFFFF);
    rchk("unmapped", 8'h0A, 32'h0);
  endtask

  task automatic t_dest_end;
    end_req <= 1'b1;
    run(32'h10, 32'h5, 32'h1D);
    after(32'h10, 32'h4, 32'h1, 1);
    chk("fc src", 32'h8, {28'h0, fc_seen});
  endtask

  task automatic t_count;
    end_req <= 1'b0;
    run(32'h30, 32'h2, 32'h1D);
    after(32'h30, 32'h0, 32'h2, 2);
    chk("end drive", 32'h3, oe_seen);
  endtask

  task automatic t_src_end;
    end_req <= 1'b1;
    waits   <= 4'h2;
    run(32'h50, 32'h4, 32'h15);
    after(32'h50, 32'h3, 32'h1, 1);
  endtask

  task automatic t_sync;
    waits <= 4'h0;
    run(32'h70, 32'h3, 32'h19);
    after(32'h70, 32'h0, 32'h3, 3);
    waits <= 4'h2;
    run(32'h90, 32'h3, 32'h19);
    after(32'h90, 32'h2, 32'h1, 1);
  endtask

  // chain mode: two descriptors, last one wraps; then an invalid descriptor and a channel re-init
  task automatic t_chain;
    wr(8'h41, 32'h2);
    wr(8'h42, 32'hA0);
    wr(8'h43, 32'hB0);
    wr(8'h40, 32'h9000);
    wr(8'h45, 32'h1);
    wr(8'h46, 32'hC0);
    wr(8'h47, 32'hD0);
    wr(8'h44, 32'hA800);
    end_req <= 1'b0;
    run(32'h0, 32'h0, 32'h5D);
    rchk("chain count", `DMAT_REG_COUNT, 32'h0);
    rchk("chain src", `DMAT_REG_SRC, 32'hC1);
    rchk("chain dst", `DMAT_REG_DST, 32'hD1);
    chk("chain writes", 32'h3, wr_seen - w0);
    rchk("chain status", `DMAT_REG_STATUS, 32'h3);
    rchk("bd0 closed", 8'h40, 32'h1000);
    rchk("bd1 closed", 8'h44, 32'h2800);
    rchk("chain wrap", `DMAT_REG_STATE, 32'h0);
    wr(`DMAT_REG_STATUS, 32'h7);
    wr(`DMAT_REG_MODE, 32'h5D);
    repeat (3) @(posedge clk_in);
    rchk("oob status", `DMAT_REG_STATUS, 32'h4);
    rchk("oob run", `DMAT_REG_MODE, 32'h5C);
    wr(`DMAT_REG_MODE, 32'h42);
    wr(`DMAT_REG_CMD, `DMAT_CMD_INIT);
    rchk("init", `DMAT_REG_MODE, 32'h40);
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    t_regs();
    t_dest_end();
    t_count();
    t_src_end();
    t_sync();
    t_chain();
    end_of_test();
  end

  // watchdog against a hung transfer
  initial begin
    #(20000 * 100);
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
